// >>> glob_regs_pkg.sv
// Constants for the global identification, reset and interrupt register group
package glob_regs_pkg;
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] OFS_CHIP_ID_LO  = 16'h0002;
  localparam logic [15:0] OFS_REV_RESET   = 16'h0003;
  localparam logic [15:0] OFS_WAKE_CTRL   = 16'h0006;
  localparam logic [15:0] OFS_VARIANT     = 16'h000F;
  localparam logic [15:0] OFS_IRQ_STAT    = 16'h0010;
  localparam logic [15:0] OFS_IRQ_MASK    = 16'h0014;
  localparam logic [15:0] OFS_PORT_STAT   = 16'h0018;
  localparam logic [15:0] OFS_PORT_MASK   = 16'h001C;
  localparam int          BIT_SOFT_RESET  = 0;
  localparam int          BIT_WAKE_POL    = 0;
  localparam int          BIT_WAKE_OE     = 1;
  localparam int          BIT_LOOKUP_IRQ  = 31;
  localparam int          BIT_TRIG_IRQ    = 30;
  localparam int          NUM_PORTS       = 3;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [3:0]  REV_ID_DEFAULT  = 4'h1;
  localparam logic [7:0]  CHIP_LO_DEFAULT = 8'h5A;
  localparam logic [7:0]  VARIANT_DEFAULT = 8'hA5;
  localparam int          SOFT_RST_CYCLES = 1;
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_READ,
    ACC_WRITE
  } acc_t;
endpackage

// >>> byte_lane.sv
// Picks one byte of a 32-bit register, big-endian within the word
`timescale 1ns/1ps
module byte_lane (
  input  wire logic [31:0] word,
  input  wire logic [1:0]  lane,
  output logic      [7:0]  byte_out
);
  always_comb begin
    case (lane)
      2'h0:    byte_out = word[31:24]; // [R10]
      2'h1:    byte_out = word[23:16];
      2'h2:    byte_out = word[15:8];
      default: byte_out = word[7:0];
    endcase
  end
endmodule

// >>> wake_pin_drive.sv
// Drives the wake event pin from the event level, enable and polarity
`timescale 1ns/1ps
module wake_pin_drive (
  input  wire logic event_active,
  input  wire logic enable,
  input  wire logic polarity,
  output logic      pin_level,
  output logic      pin_oe
);
  always_comb begin
    pin_oe    = enable;                        // [R02]
    pin_level = polarity ? event_active : ~event_active; // [R03]
  end
endmodule

// >>> global_id_reset_irq_regs.sv
// Global identification, soft reset, wake pin and top-level interrupt registers
`timescale 1ns/1ps
// Summary of operation
// R01: Writing 1 to soft reset bit pulses data path reset; bit clears itself.
// R02: Wake event pin drives only while its output enable bit is 1.
// R03: Wake pin polarity bit: 0 asserts low, 1 asserts high; resets 0.
// R04: Status bit 31 mirrors a pending lookup engine interrupt.
// R05: Status bit 30 mirrors the trigger/timestamp unit interrupt request.
// R06: Mask bit 31 gates the lookup interrupt; 0 enables, resets 0.
// R07: Mask bit 30 gates the trigger/timestamp interrupt; 0 enables, resets 0.
// R08: Port status bits 2..0 show pending interrupts of ports 3..1.
// R09: Port mask bits 2..0 gate each port; 0 enables, all reset 0.
// R10: Multi-byte registers are big-endian, bytes accessed singly in any order.
// R11: Interrupt output asserts while any unmasked status bit is set.
// R12: Reserved bits read constant and ignore writes; identity fields fixed.
module global_id_reset_irq_regs #(
  parameter logic [3:0] REV_ID     = glob_regs_pkg::REV_ID_DEFAULT,  // Arbitrary value
  parameter logic [7:0] CHIP_ID_LO = glob_regs_pkg::CHIP_LO_DEFAULT, // Arbitrary value
  parameter logic [7:0] VARIANT_ID = glob_regs_pkg::VARIANT_DEFAULT  // Arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        lookup_irq_pending,
  input  wire logic        trig_ts_irq_pending,
  input  wire logic [2:0]  port_irq_pending,
  input  wire logic        wake_event,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  output logic             datapath_reset,
  output logic             irq_out,
  output logic             wake_pin_out,
  output logic             wake_pin_oe
);

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    logic       soft_rst;
    logic       wake_oe;
    logic       wake_pol;
    logic       mask_lookup;
    logic       mask_trig;
    logic [2:0] port_mask;
    logic       stat_lookup;
    logic       stat_trig;
    logic [2:0] port_stat;
    logic       irq;
    logic       wake_lvl;
    logic       wake_en;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [31:0] stat_word;
  logic [31:0] mask_word;
  logic [31:0] pstat_word;
  logic [31:0] pmask_word;
  logic [7:0]  stat_byte;
  logic [7:0]  mask_byte;
  logic [7:0]  pstat_byte;
  logic [7:0]  pmask_byte;
  logic        wake_lvl_c;
  logic        wake_oe_c;
  logic [15:0] word_base;
  logic [1:0]  lane;

  function automatic logic is_word(input logic [15:0] a, input logic [15:0] base);
    is_word = (a[15:2] == base[15:2]);
  endfunction

  assign word_base = {reg_addr[15:2], 2'b00};
  assign lane      = reg_addr[1:0];

  // Reserved bits are tied to zero so they read constant [R12]
  assign stat_word  = {s_q.stat_lookup, s_q.stat_trig, 30'h00000000};
  assign mask_word  = {s_q.mask_lookup, s_q.mask_trig, 30'h00000000};
  assign pstat_word = {29'h00000000, s_q.port_stat};
  assign pmask_word = {29'h00000000, s_q.port_mask};

  byte_lane u_lane_stat (
    .word     (stat_word),
    .lane     (lane),
    .byte_out (stat_byte)
  );
  byte_lane u_lane_mask (
    .word     (mask_word),
    .lane     (lane),
    .byte_out (mask_byte)
  );
  byte_lane u_lane_pstat (
    .word     (pstat_word),
    .lane     (lane),
    .byte_out (pstat_byte)
  );
  byte_lane u_lane_pmask (
    .word     (pmask_word),
    .lane     (lane),
    .byte_out (pmask_byte)
  );

  wake_pin_drive u_wake (
    .event_active (wake_event),
    .enable       (s_q.wake_oe),
    .polarity     (s_q.wake_pol),
    .pin_level    (wake_lvl_c),
    .pin_oe       (wake_oe_c)
  );

  always_comb begin
    s_d          = s_q;
    s_d.rvalid   = 1'b0;
    // Self-clearing: the reset request lasts exactly one cycle [R01]
    s_d.soft_rst = 1'b0;

    // Status follows the sources as levels; clearing is done at the source
    s_d.stat_lookup = lookup_irq_pending;  // [R04]
    s_d.stat_trig   = trig_ts_irq_pending; // [R05]
    s_d.port_stat   = port_irq_pending;    // [R08]

    if (reg_wr) begin
      case (reg_addr)
        glob_regs_pkg::OFS_REV_RESET: begin
          s_d.soft_rst = reg_wdata[glob_regs_pkg::BIT_SOFT_RESET]; // [R01]
        end
        glob_regs_pkg::OFS_WAKE_CTRL: begin
          s_d.wake_oe  = reg_wdata[glob_regs_pkg::BIT_WAKE_OE];  // [R02]
          s_d.wake_pol = reg_wdata[glob_regs_pkg::BIT_WAKE_POL]; // [R03]
        end
        glob_regs_pkg::OFS_IRQ_MASK: begin
          // Bits 31 and 30 live in the most significant byte [R10]
          s_d.mask_lookup = reg_wdata[7]; // [R06]
          s_d.mask_trig   = reg_wdata[6]; // [R07]
        end
        glob_regs_pkg::OFS_PORT_MASK + 16'h0003: begin
          s_d.port_mask = reg_wdata[2:0]; // [R09]
        end
        default: begin
          // Identity, status and reserved bytes ignore writes [R12]
        end
      endcase
    end

    if (reg_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = glob_regs_pkg::RST_BYTE;
      if (is_word(word_base, glob_regs_pkg::OFS_IRQ_STAT)) begin
        s_d.rdata = stat_byte;  // [R10]
      end else if (is_word(word_base, glob_regs_pkg::OFS_IRQ_MASK)) begin
        s_d.rdata = mask_byte;
      end else if (is_word(word_base, glob_regs_pkg::OFS_PORT_STAT)) begin
        s_d.rdata = pstat_byte;
      end else if (is_word(word_base, glob_regs_pkg::OFS_PORT_MASK)) begin
        s_d.rdata = pmask_byte;
      end else begin
        case (reg_addr)
          glob_regs_pkg::OFS_CHIP_ID_LO: s_d.rdata = CHIP_ID_LO;         // [R12]
          glob_regs_pkg::OFS_REV_RESET:  s_d.rdata = {REV_ID, 4'h0};     // [R12]
          glob_regs_pkg::OFS_WAKE_CTRL:  s_d.rdata = {6'h00, s_q.wake_oe, s_q.wake_pol};
          glob_regs_pkg::OFS_VARIANT:    s_d.rdata = VARIANT_ID;         // [R12]
          default:                       s_d.rdata = glob_regs_pkg::RST_BYTE;
        endcase
      end
    end

    // Combined from registered status so the output has no input glitches
    s_d.irq = (s_q.stat_lookup & ~s_q.mask_lookup) |
              (s_q.stat_trig & ~s_q.mask_trig) |
              (|(s_q.port_stat & ~s_q.port_mask)); // [R11]

    s_d.wake_lvl = wake_lvl_c; // [R03]
    s_d.wake_en  = wake_oe_c;  // [R02]
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata      = s_q.rdata;
  assign reg_rvalid     = s_q.rvalid;
  assign datapath_reset = s_q.soft_rst;
  assign irq_out        = s_q.irq;
  assign wake_pin_out   = s_q.wake_lvl;
  assign wake_pin_oe    = s_q.wake_en;

endmodule

// >>> glob_regs_assertions.sv
// Port checks for the global id, reset and interrupt registers
`timescale 1ns/1ps
module glob_regs_assertions (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic        lookup_irq_pending,
  input wire logic        trig_ts_irq_pending,
  input wire logic [2:0]  port_irq_pending,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        datapath_reset,
  input wire logic        irq_out,
  input wire logic        wake_pin_oe
);
  logic soft_wr;
  logic oe_wr;
  logic any_src;
  assign soft_wr = reg_wr && reg_addr == 16'h0003 && reg_wdata[0];
  assign oe_wr   = reg_wr && reg_addr == 16'h0006 && reg_wdata[1];
  assign any_src = lookup_irq_pending || trig_ts_irq_pending || (|port_irq_pending);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence pulse_s;
    datapath_reset ##1 !datapath_reset;
  endsequence
  soft_rst_pulse_a: assert property (soft_wr |=> pulse_s) else $error("bad soft reset pulse");
  soft_rst_cause_a: assert property (datapath_reset |-> $past(soft_wr)) else $error("stray reset");
  read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  wake_oe_cause_a: assert property ($rose(wake_pin_oe) |-> $past(oe_wr, 2)) else $error("stray oe");
  irq_cause_a: assert property (irq_out |-> $past(any_src, 2)) else $error("irq without source");
  glob_status_a: assert property (reg_rd && reg_addr == 16'h0010 && !$past(rst) && $stable(lookup_irq_pending)
    && $stable(trig_ts_irq_pending) |=> reg_rdata == {$past(lookup_irq_pending), $past(trig_ts_irq_pending), 6'h00})
    else $error("bad status byte");
  port_status_a: assert property (reg_rd && reg_addr == 16'h001B && !$past(rst) && $stable(port_irq_pending)
    |=> reg_rdata == {5'h00, $past(port_irq_pending)}) else $error("bad port status");
  unmapped_read_a: assert property (reg_rd && reg_addr == 16'h0007 |=> reg_rdata == 8'h00) else $error("bad");
endmodule
bind global_id_reset_irq_regs glob_regs_assertions u_chk (.*);

// >>> global_id_reset_irq_regs_test.sv
// Self-checking bench for the global id, reset and interrupt registers
`timescale 1ns/1ps
module global_id_reset_irq_regs_test;
  logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, wake_event = 1'b0;
  logic        lookup_irq_pending = 1'b0, trig_ts_irq_pending = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic [2:0]  port_irq_pending = 3'h0;
  logic        reg_rvalid, datapath_reset, irq_out, wake_pin_out, wake_pin_oe;
  int          fail_count = 0, compares = 0;
  logic [15:0] ra [10] = '{16'h0002, 16'h0003, 16'h000F, 16'h0007, 16'h0010, 16'h0013,
                           16'h0006, 16'h0014, 16'h001C, 16'h001F};
  logic [7:0]  re [10] = '{glob_regs_pkg::CHIP_LO_DEFAULT, {glob_regs_pkg::REV_ID_DEFAULT, 4'h0},
                           glob_regs_pkg::VARIANT_DEFAULT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  global_id_reset_irq_regs u_dut (.*);
  always #10 mclk = ~mclk;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // An idle cycle first keeps strobes from being lowered and raised in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cyc(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    cyc(1);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    chk(reg_rvalid, 8'h01);
    chk(reg_rdata, exp);
  endtask
  task automatic stop_test;
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    #2;
    rst = 1'b0;
    for (int p = 0; p < 2; p++) begin
      foreach (ra[i]) rd(ra[i], re[i]);
      for (int i = 0; i < 6; i++) wr(ra[i], 8'hFE);
    end
    wr(16'h0014, 8'h40);
    wr(16'h0003, 8'h01);
    chk(datapath_reset, 8'h01);
    cyc(1);
    chk(datapath_reset, 8'h00);
    rd(16'h0003, {glob_regs_pkg::REV_ID_DEFAULT, 4'h0});
    rd(16'h0014, 8'h40);
    chk(wake_pin_out, 8'h01);
    wake_event = 1'b1;
    wr(16'h0006, 8'h02);
    cyc(2);
    chk({wake_pin_oe, wake_pin_out}, 8'h02);
    wr(16'h0006, 8'h03);
    cyc(2);
    chk({wake_pin_oe, wake_pin_out}, 8'h03);
    wake_event = 1'b0;
    cyc(2);
    chk({wake_pin_oe, wake_pin_out}, 8'h02);
    wr(16'h0006, 8'h00);
    cyc(2);
    chk(wake_pin_oe, 8'h00);
    lookup_irq_pending = 1'b1;
    cyc(2);
    chk(irq_out, 8'h01);
    trig_ts_irq_pending = 1'b1;
    rd(16'h0010, 8'hC0);
    wr(16'h0014, 8'h80);
    cyc(2);
    chk(irq_out, 8'h01);
    wr(16'h0014, 8'hC0);
    cyc(2);
    chk(irq_out, 8'h00);
    lookup_irq_pending = 1'b0;
    trig_ts_irq_pending = 1'b0;
    wr(16'h0014, 8'h00);
    for (int i = 0; i < 3; i++) begin
      port_irq_pending = 3'h1 << i;
      rd(16'h001B, 8'h01 << i);
      chk(irq_out, 8'h01);
      wr(16'h001F, 8'h01 << i);
      cyc(2);
      chk(irq_out, 8'h00);
      wr(16'h001F, 8'h00);
    end
    port_irq_pending = 3'h0;
    stop_test();
  end
endmodule
